// ===== rtl/dma_pkg.sv
// shared constants for the four-channel frame dma engine
package dma_pkg;
   localparam int          NUM_CH          = 4;
   localparam int          AW              = 32;
   localparam int          DW              = 16;
   localparam logic [31:0] SER_CH_B_OFFSET = 32'h0000_0040;
   localparam logic [15:0] FIFO_BYTES      = 16'h0020;
   localparam logic [15:0] WORD_BYTES      = 16'h0002;
   localparam logic [31:0] DESC_STEP       = 32'h0000_0004;
   localparam logic [31:0] CHAIN_STEP      = 32'h0000_0008;
   // register byte offsets on the axi4-lite slave
   localparam logic [7:0]  REG_MODE        = 8'h00;
   localparam logic [7:0]  REG_DELAY       = 8'h04;
   localparam logic [7:0]  REG_BURST_LIMIT = 8'h08;
   localparam logic [7:0]  REG_COMMAND     = 8'h0C;
   localparam logic [7:0]  REG_STATUS      = 8'h10;
   localparam logic [7:0]  REG_SER_BASE    = 8'h14;
   localparam logic [7:0]  REG_CMD_PTR0    = 8'h20;
   localparam logic [7:0]  REG_XFER_CNT0   = 8'h30;
   // mode register: bit0 local, bit1 bus16, bit2 irq mask all, bit3 rotate
   localparam logic [31:0] MODE_RESET      = 32'h0000_000F;
   localparam int          MODE_ROTATE_BIT = 3;
   // command block words: ctrl, src, dst, count; ctrl bits below
   localparam int          CB_CHAIN_BIT    = 0;
   localparam int          CB2_STOP_BIT    = 0;
   localparam logic [1:0]  RESP_OKAY       = 2'b00;
   localparam logic [1:0]  RESP_SLVERR     = 2'b10;
endpackage

// ===== rtl/dma_arbiter.sv
// rotating-priority request arbiter over the four channels
`default_nettype none
module dma_arbiter (
   input  wire logic       aclk,      // clock
   input  wire logic       aresetn,   // sync reset, low
   input  wire logic [3:0] req,       // channel requests
   input  wire logic       rotate,    // rotating vs fixed priority
   input  wire logic       advance,   // grant consumed
   output logic      [3:0] grant      // one-hot grant
);
   import dma_pkg::*;
   logic [1:0] last_r;
   logic [1:0] idx;

   always_comb begin
      grant = 4'h0;
      idx   = 2'h0;
      for (int k = NUM_CH; k >= 1; k--) begin
         idx = rotate ? 2'(last_r + 2'(k)) : 2'(NUM_CH - k);
         if (req[idx]) begin
            grant = 4'h0;
            grant[idx] = 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_r <= 2'h3;
      end else if (advance && grant != 4'h0) begin
         for (int k = 0; k < NUM_CH; k++) begin
            if (grant[k]) begin
               last_r <= 2'(k);
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== rtl/dma_engine.sv
// four-channel frame dma engine with command-block channel programs
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`default_nettype none
module dma_engine (
   input  wire logic        aclk,           // clock
   input  wire logic        aresetn,        // sync reset, low
   input  wire logic [7:0]  s_axi_awaddr,   // write address
   input  wire logic        s_axi_awvalid,  // write address valid
   output logic             s_axi_awready,  // write address ready
   input  wire logic [31:0] s_axi_wdata,    // write data
   input  wire logic [3:0]  s_axi_wstrb,    // write strobes
   input  wire logic        s_axi_wvalid,   // write data valid
   output logic             s_axi_wready,   // write data ready
   output logic [1:0]       s_axi_bresp,    // write response
   output logic             s_axi_bvalid,   // write response valid
   input  wire logic        s_axi_bready,   // write response ready
   input  wire logic [7:0]  s_axi_araddr,   // read address
   input  wire logic        s_axi_arvalid,  // read address valid
   output logic             s_axi_arready,  // read address ready
   output logic [31:0]      s_axi_rdata,    // read data
   output logic [1:0]       s_axi_rresp,    // read response
   output logic             s_axi_rvalid,   // read valid
   input  wire logic        s_axi_rready,   // read ready
   input  wire logic [1:0]  receive_dma_request,  // serial A/B receive requests, async
   input  wire logic [1:0]  transmit_dma_request, // serial A/B transmit requests, async
   output logic             mem_req,        // bus cycle request
   output logic             mem_we,         // bus write
   output logic [31:0]      mem_addr,       // bus byte address
   output logic [31:0]      mem_wdata,      // bus write data
   input  wire logic        mem_ack,        // bus cycle done
   input  wire logic [31:0] mem_rdata,      // bus read data
   output logic             bus_hold        // engine owns the bus
);
   import dma_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_FETCH = 3'b001,
      ST_READ  = 3'b010,
      ST_WRITE = 3'b011,
      ST_CTRL  = 3'b100,
      ST_CHAIN = 3'b101,
      ST_DELAY = 3'b110
   } state_t;

   state_t      state_r;
   logic [31:0] mode_r, delay_r, burst_lim_r, ser_base_r;
   logic [31:0] cmd_ptr_r [NUM_CH];
   logic [31:0] src_r     [NUM_CH];
   logic [31:0] dst_r     [NUM_CH];
   logic [15:0] cnt_r     [NUM_CH];
   logic [31:0] moved_r   [NUM_CH];
   logic [NUM_CH-1:0] active_r, chain_r, loaded_r, stopped_r;
   logic [1:0]  cur_r;
   logic [1:0]  word_r;
   logic [31:0] hold_r, burst_r, dly_r;
   logic [2:0]  rx_s0_r, rx_s1_r, rx_s2_r, tx_s0_r, tx_s1_r, tx_s2_r;
   logic [1:0]  rx_req_r, tx_req_r;
   logic [3:0]  req, grant;
   logic        advance, throttled;

   function automatic logic [31:0] fifo_addr(input logic [1:0] ch);
      return ser_base_r + (ch[0] ? SER_CH_B_OFFSET : 32'h0);
   endfunction

   function automatic logic is_rx(input logic [1:0] ch);
      return !ch[1];
   endfunction

   // three-stage sync; the request changes once stages two and three agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_s0_r <= 3'h0; rx_s1_r <= 3'h0; rx_s2_r <= 3'h0;
         tx_s0_r <= 3'h0; tx_s1_r <= 3'h0; tx_s2_r <= 3'h0;
         rx_req_r <= 2'h0; tx_req_r <= 2'h0;
      end else begin
         rx_s0_r <= {1'b0, receive_dma_request};
         rx_s1_r <= rx_s0_r;
         rx_s2_r <= rx_s1_r;
         tx_s0_r <= {1'b0, transmit_dma_request};
         tx_s1_r <= tx_s0_r;
         tx_s2_r <= tx_s1_r;
         for (int k = 0; k < 2; k++) begin
            if (rx_s1_r[k] == rx_s2_r[k]) rx_req_r[k] <= rx_s2_r[k];
            if (tx_s1_r[k] == tx_s2_r[k]) tx_req_r[k] <= tx_s2_r[k];
         end
      end
   end

   // stopped channels never request pacing by fifo side request
   assign req = active_r & {tx_req_r, rx_req_r};

   // a zero limit means no throttling at all, whatever the delay
   assign throttled = (burst_lim_r != 32'h0) && (burst_r >= burst_lim_r);
   assign advance   = (state_r == ST_IDLE) && (grant != 4'h0);

   dma_arbiter u_arb (
      .aclk    (aclk),
      .aresetn (aresetn),
      .req     (req),
      .rotate  (mode_r[MODE_ROTATE_BIT]),
      .advance (advance),
      .grant   (grant)
   );

   // ---------------- axi4-lite slave ----------------
   logic        aw_have_r, w_have_r;
   logic [7:0]  aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;
   logic        do_write;
   logic [3:0]  start_pulse;
   logic [3:0]  ptr_write;

   assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
   assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write      = aw_have_r && w_have_r && !s_axi_bvalid;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) if (s[b]) r[8*b +: 8] = d[8*b +: 8];
      return r;
   endfunction

   always_comb begin
      start_pulse = 4'h0;
      ptr_write   = 4'h0;
      if (do_write) begin
         if (aw_addr_r == REG_COMMAND && w_strb_r[0]) start_pulse = w_data_r[3:0];
         for (int k = 0; k < NUM_CH; k++)
            if (aw_addr_r == REG_CMD_PTR0 + 8'(4*k)) ptr_write[k] = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0; w_have_r <= 1'b0; aw_addr_r <= 8'h0;
         w_data_r <= 32'h0; w_strb_r <= 4'h0;
         s_axi_bvalid <= 1'b0; s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_have_r    <= 1'b0;
            w_have_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_r <= REG_SER_BASE || ptr_write != 4'h0)
                            ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_r <= MODE_RESET;
         delay_r <= 32'h0; burst_lim_r <= 32'h0; ser_base_r <= 32'h0;
         for (int k = 0; k < NUM_CH; k++) cmd_ptr_r[k] <= 32'h0;
      end else if (do_write) begin
         unique case (aw_addr_r)
            REG_MODE:        mode_r      <= merge(mode_r, w_data_r, w_strb_r);
            REG_DELAY:       delay_r     <= merge(delay_r, w_data_r, w_strb_r);
            REG_BURST_LIMIT: burst_lim_r <= merge(burst_lim_r, w_data_r, w_strb_r);
            REG_SER_BASE:    ser_base_r  <= merge(ser_base_r, w_data_r, w_strb_r);
            default: begin
               for (int k = 0; k < NUM_CH; k++)
                  if (ptr_write[k]) cmd_ptr_r[k] <= merge(cmd_ptr_r[k], w_data_r, w_strb_r);
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0; s_axi_rdata <= 32'h0; s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= RESP_OKAY;
         s_axi_rdata  <= 32'h0;
         unique case (s_axi_araddr)
            REG_MODE:        s_axi_rdata <= mode_r;
            REG_DELAY:       s_axi_rdata <= delay_r;
            REG_BURST_LIMIT: s_axi_rdata <= burst_lim_r;
            REG_COMMAND:     s_axi_rdata <= 32'h0;
            REG_STATUS:      s_axi_rdata <= {20'h0, stopped_r, 4'h0, active_r};
            REG_SER_BASE:    s_axi_rdata <= ser_base_r;
            default: begin
               s_axi_rresp <= RESP_SLVERR;
               for (int k = 0; k < NUM_CH; k++) begin
                  if (s_axi_araddr == REG_CMD_PTR0 + 8'(4*k)) begin
                     s_axi_rdata <= cmd_ptr_r[k];
                     s_axi_rresp <= RESP_OKAY;
                  end
                  if (s_axi_araddr == REG_XFER_CNT0 + 8'(4*k)) begin
                     s_axi_rdata <= moved_r[k];
                     s_axi_rresp <= RESP_OKAY;
                  end
               end
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------- channel engine ----------------
   assign mem_req  = (state_r == ST_FETCH) || (state_r == ST_READ) ||
                     (state_r == ST_WRITE) || (state_r == ST_CTRL) || (state_r == ST_CHAIN);
   assign bus_hold = mem_req;

   always_comb begin
      mem_we    = 1'b0;
      mem_addr  = 32'h0;
      mem_wdata = 32'h0;
      unique case (state_r)
         ST_FETCH: mem_addr = cmd_ptr_r[cur_r] + 32'(word_r) * DESC_STEP;
         ST_CTRL:  mem_addr = cmd_ptr_r[cur_r] + 32'(NUM_CH) * DESC_STEP;
         // chain list sits at the data pointer: destination on receive, source on transmit
         ST_CHAIN: mem_addr = (is_rx(cur_r) ? dst_r[cur_r] : src_r[cur_r])
                              + 32'(word_r) * DESC_STEP;
         // receive reads fifo, transmit reads memory
         ST_READ:  mem_addr = is_rx(cur_r) ? fifo_addr(cur_r) : src_r[cur_r];
         ST_WRITE: begin
            mem_we    = 1'b1;
            mem_addr  = is_rx(cur_r) ? dst_r[cur_r] : fifo_addr(cur_r);
            mem_wdata = hold_r;
         end
         default: mem_addr = 32'h0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= ST_IDLE; cur_r <= 2'h0; word_r <= 2'h0; hold_r <= 32'h0;
         burst_r <= 32'h0; dly_r <= 32'h0;
         active_r <= 4'h0; chain_r <= 4'h0; loaded_r <= 4'h0; stopped_r <= 4'h0;
         for (int k = 0; k < NUM_CH; k++) begin
            src_r[k] <= 32'h0; dst_r[k] <= 32'h0; cnt_r[k] <= 16'h0; moved_r[k] <= 32'h0;
         end
      end else begin
         // new pointer plus start rearms a channel
         for (int k = 0; k < NUM_CH; k++) begin
            if (ptr_write[k]) loaded_r[k] <= 1'b1;
            if (start_pulse[k] && loaded_r[k] && !active_r[k]) begin
               active_r[k]  <= 1'b1;
               stopped_r[k] <= 1'b0;
               loaded_r[k]  <= 1'b0;
               cnt_r[k]     <= 16'h0;
               moved_r[k]   <= 32'h0;
            end
         end
         unique case (state_r)
            ST_IDLE: begin
               burst_r <= 32'h0;
               if (grant != 4'h0) begin
                  for (int k = 0; k < NUM_CH; k++) if (grant[k]) cur_r <= 2'(k);
                  word_r  <= 2'h0;
                  state_r <= ST_FETCH;
               end
            end
            ST_FETCH: if (mem_ack) begin
               // once a block is loaded only word 0 is read again, and that word is discarded
               if (cnt_r[cur_r] != 16'h0) begin
                  state_r <= ST_READ;
               end else begin
                  unique case (word_r)
                     2'h0: chain_r[cur_r] <= mem_rdata[CB_CHAIN_BIT];
                     2'h1: src_r[cur_r]   <= mem_rdata;
                     2'h2: dst_r[cur_r]   <= mem_rdata;
                     2'h3: cnt_r[cur_r]   <= mem_rdata[15:0];
                  endcase
                  word_r <= 2'(word_r + 2'h1);
                  if (word_r == 2'h3)
                     state_r <= (mem_rdata[15:0] == 16'h0) ? ST_CTRL : ST_READ;
               end
            end
            ST_READ: if (mem_ack) begin
               hold_r  <= mem_rdata;
               state_r <= ST_WRITE;
            end
            ST_WRITE: if (mem_ack) begin
               // words keep moving while the request stays high and the burst limit is not reached; a late-dropping request moves one more
               if (is_rx(cur_r)) dst_r[cur_r] <= dst_r[cur_r] + 32'(WORD_BYTES);
               else              src_r[cur_r] <= src_r[cur_r] + 32'(WORD_BYTES);
               moved_r[cur_r] <= moved_r[cur_r] + 32'(WORD_BYTES);
               burst_r        <= burst_r + 32'h1;
               cnt_r[cur_r]   <= (cnt_r[cur_r] > WORD_BYTES) ? cnt_r[cur_r] - WORD_BYTES
                                                             : 16'h0;
               if (cnt_r[cur_r] <= WORD_BYTES) begin
                  word_r  <= 2'h0;
                  // chained piece ends: fetch next element, request falls meanwhile
                  state_r <= chain_r[cur_r] ? ST_CHAIN : ST_CTRL;
               end else if (!req[cur_r] || throttled) begin
                  dly_r   <= delay_r;
                  state_r <= ST_DELAY;
               end else begin
                  state_r <= ST_READ;
               end
            end
            ST_CHAIN: if (mem_ack) begin
               // element at the data pointer: next pointer then 16-bit byte count
               word_r <= 2'(word_r + 2'h1);
               if (word_r == 2'h0) begin
                  hold_r <= mem_rdata;
               end else begin
                  if (is_rx(cur_r)) dst_r[cur_r] <= hold_r;
                  else              src_r[cur_r] <= hold_r;
                  cnt_r[cur_r] <= mem_rdata[15:0];
                  if (mem_rdata[15:0] == 16'h0) begin
                     state_r <= ST_CTRL;
                  end else begin
                     dly_r   <= delay_r;
                     state_r <= ST_DELAY;
                  end
               end
            end
            ST_CTRL: if (mem_ack) begin
               // conditional stop once the count is spent
               if (mem_rdata[CB2_STOP_BIT]) begin
                  active_r[cur_r]  <= 1'b0;
                  stopped_r[cur_r] <= 1'b1;
               end
               state_r <= ST_IDLE;
            end
            ST_DELAY: begin
               if (dly_r == 32'h0) state_r <= ST_IDLE;
               else dly_r <= dly_r - 32'h1;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// ===== testbench/dma_engine_chk.sv
// concurrent checks on the dma engine ports
`default_nettype none
module dma_engine_chk (
   input wire logic        aclk,          // clock
   input wire logic        aresetn,       // reset, low
   input wire logic        s_axi_awvalid, // aw valid
   input wire logic        s_axi_awready, // aw ready
   input wire logic        s_axi_wvalid,  // w valid
   input wire logic        s_axi_wready,  // w ready
   input wire logic [1:0]  s_axi_bresp,   // b resp
   input wire logic        s_axi_bvalid,  // b valid
   input wire logic        s_axi_bready,  // b ready
   input wire logic        s_axi_arvalid, // ar valid
   input wire logic        s_axi_arready, // ar ready
   input wire logic [31:0] s_axi_rdata,   // r data
   input wire logic        s_axi_rvalid,  // r valid
   input wire logic        s_axi_rready,  // r ready
   input wire logic        mem_req,       // bus req
   input wire logic        mem_we,        // bus write
   input wire logic [31:0] mem_addr,      // bus addr
   input wire logic        mem_ack,       // bus ack
   input wire logic        bus_hold       // bus owned
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence b_stall;
      s_axi_bvalid && !s_axi_bready;
   endsequence
   AST_BUS_HOLD: assert property (bus_hold == mem_req)
      else $error("bus hold differs from bus request");
   AST_MEM_HOLD: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
      && $stable(mem_we)) else $error("bus cycle changed before ack");
   AST_WR_ANSWER: assert property (wr_taken |-> ##2 s_axi_bvalid)
      else $error("write response late");
   AST_B_HOLD: assert property (b_stall |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   AST_AW_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during response");
   AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata)
      && s_axi_rvalid) else $error("read data dropped early");
   AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken during response");
endmodule
bind dma_engine dma_engine_chk chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .mem_req(mem_req),
   .mem_we(mem_we), .mem_addr(mem_addr), .mem_ack(mem_ack), .bus_hold(bus_hold)
);
`default_nettype wire

// ===== testbench/dma_mem_model.sv
// memory and serial fifo model on the engine's bus port
`default_nettype none
module dma_mem_model #(
   parameter logic [31:0] FIFO_LO = 32'h0000_1000
) (
   input  wire logic        aclk,      // clock
   input  wire logic        mem_req,   // bus req
   input  wire logic        mem_we,    // bus write
   input  wire logic [31:0] mem_addr,  // byte addr
   input  wire logic [31:0] mem_wdata, // write data
   output var  logic        mem_ack,   // cycle done
   output var  logic [31:0] mem_rdata  // read data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] m [0:255];
   logic [31:0] wa [0:63];
   logic [31:0] wd [0:63];
   logic [31:0] ra [0:63];
   logic [15:0] fifo_n;
   int          nw, nr, wait_n;
   initial begin
      {mem_ack, mem_rdata, fifo_n} = '0;
      {nw, nr, wait_n} = '0;
   end
   // latency varies 0..2 so prompt and slow answers both occur
   always @(posedge aclk) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;  // inverts each cycle, so outside an answer the old word shows on alternate cycles
      if (mem_req && !mem_ack) begin
         if (wait_n < (nr + nw) % 3) wait_n <= wait_n + 1;
         else begin
            wait_n <= 0;
            mem_ack <= 1'b1;
            if (mem_we) begin
               wa[nw[5:0]] <= mem_addr;
               wd[nw[5:0]] <= mem_wdata;
               nw <= nw + 1;
            end else begin
               ra[nr[5:0]] <= mem_addr;
               nr <= nr + 1;
               if (mem_addr >= FIFO_LO) begin  // serial fifo region
                  mem_rdata <= {16'h0000, 16'hA000 | fifo_n};
                  fifo_n <= fifo_n + 16'h0001;
               end else mem_rdata <= m[mem_addr[9:2]];
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== testbench/dma_engine_test.sv
// self-checking bench for the four-channel frame dma engine
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end
module dma_engine_test import dma_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] SER_BASE = 32'h0000_1000;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata;
   logic [1:0]  rx_req, tx_req;
   wire  logic  awready, wready, bvalid, arready, rvalid, mem_req, mem_we, mem_ack, bus_hold;
   wire  logic [1:0]  bresp, rresp;
   wire  logic [31:0] rdata, mem_addr, mem_wdata, mem_rdata;
   int          n_mismatch, checks_done;
   dma_engine dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .receive_dma_request(rx_req), .transmit_dma_request(tx_req), .mem_req(mem_req),
      .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata), .bus_hold(bus_hold));
   dma_mem_model #(.FIFO_LO(SER_BASE)) mem (
      .aclk(aclk), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ready rises with the request and falls at the edge that takes the answer
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_t, w_t, b_t;
      b_t = 1'b0;
      @(posedge aclk);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
      while (!b_t) begin
         @(negedge aclk);
         {aw_t, w_t, b_t, r} = {awvalid && awready, wvalid && wready, bvalid && bready, bresp};
         @(posedge aclk);
         if (aw_t) awvalid <= 1'b0;
         if (w_t) wvalid <= 1'b0;
         if (b_t) bready <= 1'b0;
      end
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic a_t, t;
      t = 1'b0;
      @(posedge aclk);
      {araddr, arvalid, rready} <= {a, 2'b11};
      while (!t) begin
         @(negedge aclk);
         {a_t, t, d, r} = {arvalid && arready, rvalid && rready, rdata, rresp};
         @(posedge aclk);
         if (a_t) arvalid <= 1'b0;
         if (t) rready <= 1'b0;
      end
   endtask
   task automatic start_ch(input int ch, input logic [31:0] p);
      logic [1:0] r;
      axi_wr(REG_SER_BASE, SER_BASE, r);
      axi_wr(REG_CMD_PTR0 + 8'(4 * ch), p, r);
      axi_wr(REG_COMMAND, 32'h1 << ch, r);
      `CHK("start resp", RESP_OKAY, r)
   endtask
   task automatic wait_stop(input int ch, input logic [31:0] n_b);
      logic [31:0] d;
      logic [1:0]  r;
      int          n;
      d = '0;
      for (n = 0; n < 100 && d[8 + ch] !== 1'b1; n++) axi_rd(REG_STATUS, d, r);
      `CHK("stopped", 1'b1, d[8 + ch])
      axi_rd(REG_XFER_CNT0 + 8'(4 * ch), d, r);
      `CHK("bytes moved", n_b, d)
   endtask
   task automatic t_reset();
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(REG_MODE, d, r);
      `CHK("mode", MODE_RESET, d)
      axi_rd(REG_DELAY, d, r);
      `CHK("delay", 32'h0, d)
      axi_rd(REG_BURST_LIMIT, d, r);
      `CHK("limit", 32'h0, d)
      axi_rd(8'hFC, d, r);
      `CHK("unmapped resp", RESP_SLVERR, r)
      $display("test reset done");
   endtask
   task automatic t_rx0();
      int b, rb;
      {b, rb} = {mem.nw, mem.nr};
      rx_req[0] <= 1'b1;
      start_ch(0, 32'h0000_0100);
      wait_stop(0, 32'h4);
      `CHK("rx src 0", SER_BASE, mem.ra[rb + 4])
      `CHK("rx src 1", SER_BASE, mem.ra[rb + 5])
      `CHK("rx dst 0", 32'h0000_0200, mem.wa[b])
      `CHK("rx dst 1", 32'h0000_0202, mem.wa[b + 1])
      `CHK("rx data 0", 16'hA000, mem.wd[b][15:0])
      `CHK("rx data 1", 16'hA001, mem.wd[b + 1][15:0])
      $display("test rx0 done");
   endtask
   task automatic t_rx_stopped();
      logic [1:0] r;
      int         b;
      b = mem.nw;
      repeat (40) @(posedge aclk);
      `CHK("idle after stop", b, mem.nw)
      axi_wr(REG_COMMAND, 32'h1, r);  // start without a fresh pointer
      repeat (40) @(posedge aclk);
      `CHK("start needs pointer", b, mem.nw)
      rx_req[0] <= 1'b0;
      $display("test rx stopped done");
   endtask
   task automatic t_tx3();
      int b, rb;
      {b, rb} = {mem.nw, mem.nr};
      tx_req[1] <= 1'b1;
      start_ch(3, 32'h0000_0180);
      wait_stop(3, 32'h4);
      tx_req[1] <= 1'b0;
      `CHK("tx src 0", 32'h0000_0300, mem.ra[rb + 4])
      `CHK("tx src 1", 32'h0000_0302, mem.ra[rb + 5])
      `CHK("tx dst 0", SER_BASE + SER_CH_B_OFFSET, mem.wa[b])
      `CHK("tx dst 1", SER_BASE + SER_CH_B_OFFSET, mem.wa[b + 1])
      `CHK("tx data", 32'h1234_5678, mem.wd[b + 1])
      $display("test tx3 done");
   endtask
   task automatic t_rx_chain();
      int b, rb;
      {b, rb} = {mem.nw, mem.nr};
      rx_req[1] <= 1'b1;
      start_ch(1, 32'h0000_0140);
      wait_stop(1, 32'h20);
      rx_req[1] <= 1'b0;
      `CHK("chain src", SER_BASE + SER_CH_B_OFFSET, mem.ra[rb + 4])
      `CHK("chain last dst", 32'h0000_029E, mem.wa[b + 15])
      `CHK("chain elem 0", 32'h0000_02A0, mem.ra[rb + 20])
      `CHK("chain elem 1", 32'h0000_02A4, mem.ra[rb + 21])
      `CHK("chain stop", 32'h0000_0150, mem.ra[rb + 22])
      $display("test rx chain done");
   endtask
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, rx_req, tx_req} = '0;
      {n_mismatch, checks_done} = '0;
      // transfer block then stop block for each program
      {mem.m[8'h40], mem.m[8'h41], mem.m[8'h42]} = {32'h0, 32'h0, 32'h0000_0200};
      {mem.m[8'h43], mem.m[8'h44]} = {32'h4, 32'h1};
      {mem.m[8'h60], mem.m[8'h61], mem.m[8'h62]} = {32'h0, 32'h0000_0300, 32'h0};
      {mem.m[8'h63], mem.m[8'h64], mem.m[8'hC0]} = {32'h4, 32'h1, 32'h1234_5678};
      // chained receive: one 32-byte piece, then an empty element past the buffer
      {mem.m[8'h50], mem.m[8'h51], mem.m[8'h52]} = {32'h1, 32'h0, 32'h0000_0280};
      {mem.m[8'h53], mem.m[8'h54]} = {32'h20, 32'h1};
      {mem.m[8'hA8], mem.m[8'hA9]} = {32'h0000_02C0, 32'h0};
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_rx0();
      t_rx_stopped();
      t_tx3();
      t_rx_chain();
      give_verdict();
   end
   initial begin
      #60us;
      n_mismatch++;
      give_verdict();
   end
endmodule
`default_nettype wire
